// file: common/atten_cfg.svh
`ifndef ATTEN_CFG_SVH
`define ATTEN_CFG_SVH

// ----------------------------------------
// serial word layout
// ----------------------------------------
`define ATT_WORD_W 16
`define ATT_BYTE_W 8
`define ATT_SREG_RST 16'h0000

// ----------------------------------------
// channel address codes
// ----------------------------------------
`define ATT_ADDR_CH1 8'h00
`define ATT_ADDR_CH2 8'h01
`define ATT_ADDR_CH3 8'h02

// ----------------------------------------
// data byte ranges
// ----------------------------------------
`define ATT_FINE_MAX 8'h1F
`define ATT_MID_MAX 8'h3F
`define ATT_COARSE_MAX 8'h4E
`define ATT_MID_BASE 8'h20
`define ATT_COARSE_BASE 8'h40
`define ATT_MID_OFS 8'h20
`define ATT_COARSE_OFS 8'h60
`define ATT_MUTE_HALF_DB 8'hC8
`define ATT_MUTE_CODE 8'hFF

`endif

// file: common/atten_pkg.sv
package atten_pkg;

    // address byte sits in the upper eight bits of the word
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] data;
    } cmd_word_t;

    // one channel setting: half_db counts 0.5 dB units
    typedef struct packed {
        logic mute;
        logic [7:0] code;
        logic [7:0] half_db;
    } chan_set_t;

    typedef enum {
        RANGE_FINE,
        RANGE_MID,
        RANGE_COARSE,
        RANGE_MUTE
    } range_t;

    typedef enum {
        LOAD_HIGH,
        LOAD_LOW
    } load_state_t;

endpackage

// file: hw/atten_serial.sv
`timescale 1ns/1ps
`include "atten_cfg.svh"
// Behaviour
// - address byte 0,1,2 picks channel 1,2,3
// - data byte decodes in 0.5/1/2 dB ranges
// - data 0x4F..0xFF mutes addressed channel
// - data in sampled on serial clock rise
// - shifting only while latch line low
// - oldest bit leaves on chain output
// - latch line rise captures shift register
// - latched word decoded onto addressed channel
// - unaddressed channels keep their setting
// - every channel muted from power-up
// - chain: low, clock bits, rise latches all
module atten_serial #(
    parameter int NUM_CH = 3
) (
    input logic CLK,
    input logic RST,
    input logic SCLK,
    input logic LOAD_N,
    input logic SDI,
    output logic SDO,
    output atten_pkg::chan_set_t CH1_SET,
    output atten_pkg::chan_set_t CH2_SET,
    output atten_pkg::chan_set_t CH3_SET,
    output atten_pkg::cmd_word_t LAST_CMD,
    output logic CMD_UPD
);
    import atten_pkg::*;

    localparam int WORD_W = `ATT_WORD_W;

    // ----------------------------------------
    // link domain: shift register
    // ----------------------------------------
    logic [WORD_W-1:0] sreg_q;
    logic [WORD_W-1:0] sreg_d;
    logic sdo_q;
    logic sreg_top;
    logic shift_en;

    assign shift_en = ~LOAD_N;
    assign sreg_top = sreg_q[WORD_W-1];
    assign sreg_d = shift_en ? {sreg_q[WORD_W-2:0], SDI} : sreg_q;

    // the serial clock stops between frames, so nothing here
    // may wait for an edge after the latch line rises
    always_ff @(posedge SCLK or posedge RST) begin
        if (RST) begin
            sreg_q <= `ATT_SREG_RST;
        end else begin
            sreg_q <= sreg_d;
        end
    end

    always_ff @(posedge SCLK or posedge RST) begin
        if (RST) begin
            sdo_q <= 1'b0;
        end else if (shift_en) begin
            sdo_q <= sreg_top;
        end
    end

    assign SDO = sdo_q;

    // ----------------------------------------
    // latch line into the system clock
    // ----------------------------------------
    logic ld_s1_q;
    logic ld_s2_q;
    logic ld_s3_q;
    load_state_t ld_state_q;
    load_state_t ld_state_d;
    logic ld_agree_hi;
    logic ld_agree_lo;
    logic load_rise;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ld_s1_q <= 1'b1;
            ld_s2_q <= 1'b1;
            ld_s3_q <= 1'b1;
        end else begin
            ld_s1_q <= LOAD_N;
            ld_s2_q <= ld_s1_q;
            ld_s3_q <= ld_s2_q;
        end
    end

    assign ld_agree_hi = ld_s2_q & ld_s3_q;
    assign ld_agree_lo = ~ld_s2_q & ~ld_s3_q;

    always_comb begin
        ld_state_d = ld_state_q;
        unique case (ld_state_q)
            LOAD_HIGH: begin
                if (ld_agree_lo) begin
                    ld_state_d = LOAD_LOW;
                end
            end
            LOAD_LOW: begin
                if (ld_agree_hi) begin
                    ld_state_d = LOAD_HIGH;
                end
            end
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ld_state_q <= LOAD_HIGH;
        end else begin
            ld_state_q <= ld_state_d;
        end
    end

    assign load_rise = (ld_state_q == LOAD_LOW) && ld_agree_hi;

    // ----------------------------------------
    // command latch
    // ----------------------------------------
    // the shift register is frozen while the latch line is high,
    // so the word is stable by the time the synchronised rise is seen
    cmd_word_t cmd_q;
    cmd_word_t cmd_d;
    logic upd_q;

    assign cmd_d = load_rise ? cmd_word_t'(sreg_q) : cmd_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cmd_q <= cmd_word_t'(`ATT_SREG_RST);
            upd_q <= 1'b0;
        end else begin
            cmd_q <= cmd_d;
            upd_q <= load_rise;
        end
    end

    assign LAST_CMD = cmd_q;
    assign CMD_UPD = upd_q;

    // ----------------------------------------
    // data byte decode
    // ----------------------------------------
    logic [7:0] code;
    range_t range;
    logic [7:0] mid_steps;
    logic [7:0] coarse_steps;
    logic [7:0] half_db;
    chan_set_t new_set;

    assign code = cmd_q.data;
    assign range = (code <= `ATT_FINE_MAX) ? RANGE_FINE :
                   (code <= `ATT_MID_MAX) ? RANGE_MID :
                   (code <= `ATT_COARSE_MAX) ? RANGE_COARSE : RANGE_MUTE;
    assign mid_steps = code - `ATT_MID_BASE;
    assign coarse_steps = code - `ATT_COARSE_BASE;

    always_comb begin
        half_db = `ATT_MUTE_HALF_DB;
        unique case (range)
            RANGE_FINE: half_db = code;
            RANGE_MID: half_db = `ATT_MID_OFS + {mid_steps[6:0], 1'b0};
            RANGE_COARSE: half_db = `ATT_COARSE_OFS + {coarse_steps[5:0], 2'b00};
            RANGE_MUTE: half_db = `ATT_MUTE_HALF_DB;
        endcase
    end

    assign new_set.mute = (range == RANGE_MUTE);
    assign new_set.code = code;
    assign new_set.half_db = half_db;

    // ----------------------------------------
    // per-channel setting registers
    // ----------------------------------------
    localparam logic [7:0] CH_ADDR [3] = '{`ATT_ADDR_CH1, `ATT_ADDR_CH2, `ATT_ADDR_CH3};
    localparam chan_set_t MUTE_SET = '{mute: 1'b1, code: `ATT_MUTE_CODE, half_db: `ATT_MUTE_HALF_DB};

    chan_set_t ch_q [NUM_CH];
    logic [NUM_CH-1:0] ch_hit;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        // an address that hits no channel leaves every setting alone
        assign ch_hit[i] = upd_q && (cmd_q.addr == CH_ADDR[i]);

        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                ch_q[i] <= MUTE_SET;
            end else if (ch_hit[i]) begin
                ch_q[i] <= new_set;
            end
        end
    end

    assign CH1_SET = ch_q[0];
    assign CH2_SET = ch_q[1];
    assign CH3_SET = ch_q[2];

    // ----------------------------------------
    // link domain checks
    // ----------------------------------------
    chk_shift_in: assert property (
        @(posedge SCLK) disable iff (RST)
        !LOAD_N |=> sreg_q[0] == $past(SDI))
    else $error("serial input bit not shifted in");

    chk_shift_hold: assert property (
        @(posedge SCLK) disable iff (RST)
        LOAD_N |=> $stable(sreg_q))
    else $error("shift register moved with latch line high");

    chk_chain_out: assert property (
        @(posedge SCLK) disable iff (RST)
        !LOAD_N |=> SDO == $past(sreg_top))
    else $error("chain output is not the oldest bit");

    chk_chain_hold: assert property (
        @(posedge SCLK) disable iff (RST)
        LOAD_N |=> $stable(SDO))
    else $error("chain output moved with latch line high");

    // ----------------------------------------
    // system clock checks
    // ----------------------------------------
    sequence seq_frame_low;
        ld_state_q == LOAD_LOW;
    endsequence

    sequence seq_frame_end;
        seq_frame_low ##1 ld_state_q == LOAD_HIGH;
    endsequence

    chk_latch_edge: assert property (
        @(posedge CLK) disable iff (RST)
        seq_frame_end |-> CMD_UPD && LAST_CMD == cmd_word_t'($past(sreg_q)))
    else $error("latch rise did not capture the word");

    chk_latch_only: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD |-> $past(ld_state_q) == LOAD_LOW && ld_state_q == LOAD_HIGH)
    else $error("update without a closed frame");

    chk_ch1_addr: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH1 |=> CH1_SET.code == $past(LAST_CMD.data))
    else $error("channel one not updated by its address");

    chk_fine_step: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH2 && LAST_CMD.data <= `ATT_FINE_MAX
        |=> !CH2_SET.mute && CH2_SET.half_db == CH2_SET.code)
    else $error("fine range step wrong");

    chk_mute_code: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH3 && LAST_CMD.data > `ATT_COARSE_MAX
        |=> CH3_SET.mute && CH3_SET.half_db == `ATT_MUTE_HALF_DB)
    else $error("mute code did not mute");

    chk_other_keep: assert property (
        @(posedge CLK) disable iff (RST)
        !(CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH1) |=> $stable(CH1_SET))
    else $error("channel one changed without its address");

    chk_bad_addr: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD && LAST_CMD.addr > `ATT_ADDR_CH3
        |=> $stable(CH1_SET) && $stable(CH2_SET) && $stable(CH3_SET))
    else $error("unknown address changed a channel");

    chk_reset_mute: assert property (
        @(posedge CLK)
        RST |-> CH1_SET.mute && CH2_SET.mute && CH3_SET.mute)
    else $error("channel not muted in reset");

    chk_upd_pulse: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD |=> !CMD_UPD)
    else $error("update pulse longer than one cycle");

    chk_ch2_keep: assert property (
        @(posedge CLK) disable iff (RST)
        !(CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH2) |=> $stable(CH2_SET))
    else $error("channel two changed without its address");

    chk_ch3_keep: assert property (
        @(posedge CLK) disable iff (RST)
        !(CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH3) |=> $stable(CH3_SET))
    else $error("channel three changed without its address");

    chk_ch3_apply: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH3
        |=> CH3_SET.code == $past(LAST_CMD.data)
        && CH3_SET.mute == ($past(LAST_CMD.data) > `ATT_COARSE_MAX))
    else $error("channel three not set by its address");

    // one dB per code from the middle range base: twice the code less the base, in half dB
    chk_mid_step: assert property (
        @(posedge CLK) disable iff (RST)
        CMD_UPD && LAST_CMD.addr == `ATT_ADDR_CH2 && LAST_CMD.data inside {[`ATT_MID_BASE:`ATT_MID_MAX]}
        |=> !CH2_SET.mute && CH2_SET.half_db == $past(LAST_CMD.data) + $past(LAST_CMD.data) - `ATT_MID_BASE)
    else $error("middle range step wrong");

endmodule

// file: dv/atten_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// controller side of the three-wire link
// ----------------------------------------
module atten_host_model (
    output logic SCLK,
    output logic LOAD_N,
    output logic SDI,
    input wire logic SDO
);
    initial begin
        SCLK = 1'b0;
        LOAD_N = 1'b1;
        SDI = 1'b0;
    end

    // serial clock stands still outside frames except in idle_pulses; slow stretches every low phase
    task automatic frame(input logic [31:0] bits, input int n, input int slow, output logic [31:0] seen);
        seen = '0;
        LOAD_N = 1'b0;
        // odd setup keeps serial clock edges off the system clock edges
        #(165 + slow);
        for (int i = n - 1; i >= 0; i--) begin
            SDI = bits[i];
            #32 SCLK = 1'b1;
            #16 seen[i] = SDO;
            #16 SCLK = 1'b0;
            #(slow);
        end
        #32 LOAD_N = 1'b1;
        // released data line must not keep looking valid
        SDI = ~SDI;
    endtask

    // clock pulses with the latch line high must leave the shift register alone
    task automatic idle_pulses(input int n);
        SDI = 1'b1;
        for (int i = 0; i < n; i++) begin
            #32 SCLK = 1'b1;
            #32 SCLK = 1'b0;
        end
    endtask
endmodule

// file: dv/atten_serial_tb_top.sv
`timescale 1ns/1ps
module atten_serial_tb_top;
    import atten_pkg::*;
    logic clk;
    logic rst;
    wire logic sclk;
    wire logic load_n;
    wire logic sdi;
    logic sdo;
    logic cmd_upd;
    cmd_word_t last_cmd;
    chan_set_t ch [3];
    chan_set_t exp_ch [3];
    logic [15:0] prev_word;
    int miscompares = 0;
    int n_tests = 0;

    atten_serial dut (.CLK(clk), .RST(rst), .SCLK(sclk), .LOAD_N(load_n), .SDI(sdi), .SDO(sdo),
        .CH1_SET(ch[0]), .CH2_SET(ch[1]), .CH3_SET(ch[2]), .LAST_CMD(last_cmd), .CMD_UPD(cmd_upd));
    atten_host_model host (.SCLK(sclk), .LOAD_N(load_n), .SDI(sdi), .SDO(sdo));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ----------------------------------------
    // checking helpers
    // ----------------------------------------
    function automatic chan_set_t exp_set(input logic [7:0] c);
        if (c <= 8'h1F) return '{1'b0, c, c};
        if (c <= 8'h3F) return '{1'b0, c, 8'd32 + 8'd2 * (c - 8'h20)};
        if (c <= 8'h4E) return '{1'b0, c, 8'd96 + 8'd4 * (c - 8'h40)};
        return '{1'b1, c, 8'hC8};
    endfunction

    task automatic check(input logic [16:0] got, input logic [16:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("miscompares %0d n_tests %0d", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // wait for the latch pulse, then the channel update one cycle later
    task automatic settle(input logic [15:0] w);
        int k;
        k = 0;
        while (cmd_upd !== 1'b1 && k < 40) begin
            @(posedge clk);
            #1;
            k++;
        end
        if (cmd_upd !== 1'b1) begin
            check(1'b0, 1'b1, "latch pulse timeout");
            finish_test();
        end
        check({1'b0, last_cmd}, {1'b0, w}, "latched word");
        @(posedge clk);
        #1;
        check(cmd_upd, 1'b0, "pulse length");
        if (w[15:8] <= 8'h02) exp_ch[w[15:8]] = exp_set(w[7:0]);
        for (int i = 0; i < 3; i++) check(ch[i], exp_ch[i], "channel setting");
        prev_word = w;
    endtask

    task automatic send_cmd(input logic [7:0] a, input logic [7:0] d, input int slow);
        logic [31:0] seen;
        host.frame({16'h0000, a, d}, 16, slow, seen);
        settle({a, d});
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic test_reset();
        for (int i = 0; i < 3; i++) exp_ch[i] = '{1'b1, 8'hFF, 8'hC8};
        for (int i = 0; i < 3; i++) check(ch[i], exp_ch[i], "power-up mute");
        check({1'b0, last_cmd}, 17'h0_0000, "reset word");
        check(sdo, 1'b0, "reset chain out");
    endtask

    // reset again in mid-run: settings and shift register start over
    task automatic test_power_cycle();
        send_cmd(8'h02, 8'h10, 0);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        test_reset();
        prev_word = 16'h0000;
    endtask

    task automatic test_decode();
        logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h1F, 8'h20, 8'h21, 8'h3F,
                                   8'h40, 8'h41, 8'h4E, 8'h4F, 8'h80, 8'hFF};
        for (int i = 0; i < 12; i++) send_cmd(8'(i % 3), codes[i], (i % 2) * 40);
        send_cmd(8'h00, 8'h10, 0);
        send_cmd(8'h00, 8'h50, 0);
    endtask

    task automatic test_unknown_addr();
        send_cmd(8'h03, 8'h05, 0);
        send_cmd(8'hFF, 8'h00, 0);
    endtask

    // two words back to back: first leaves on the chain output
    task automatic test_chain();
        logic [31:0] seen;
        logic [15:0] w1;
        logic [15:0] w2;
        w1 = 16'h02_A5;
        w2 = 16'h01_2A;
        host.idle_pulses(3);
        host.frame({w1, w2}, 32, 0, seen);
        check({1'b0, seen[31:16]}, {1'b0, prev_word}, "old contents out");
        check({1'b0, seen[15:0]}, {1'b0, w1}, "first word out");
        settle(w2);
    endtask

    initial begin
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        #1;
        test_reset();
        test_decode();
        test_unknown_addr();
        test_power_cycle();
        test_chain();
        finish_test();
    end
endmodule
